// ===== hdl/bus_unit_consts.svh
`ifndef BUS_UNIT_CONSTS_SVH
`define BUS_UNIT_CONSTS_SVH

// cycle status codes; only the code tells memory from i/o cycles
`define STATUS_IDLE 4'hf
`define STATUS_MEM_READ 4'h8
`define STATUS_MEM_WRITE 4'h9
`define STATUS_IO_READ 4'ha
`define STATUS_IO_WRITE 4'hb
`define STATUS_LOCKED 4'h4

// access sizes
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

// field positions and counts
`define SPACE_MSB 31
`define SPACE_LSB 30
`define BURST_LAST_BEAT 3'h7
`define WBUF_DEPTH 4
`define WBUF_WIDTH 66
`define SYNC_WIDTH 19

`endif

// ===== hdl/bus_unit_pkg.sv
package bus_unit_pkg;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_SHORT = 7'h04,
    ST_WORD1 = 7'h08,
    ST_WORD2 = 7'h10,
    ST_BURST = 7'h20,
    ST_HOLD = 7'h40
  } bus_state_t;

  typedef struct packed {
    bus_state_t state;
    logic write;
    logic io;
    logic burst;
    logic lock;
    logic lock_wr;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rbuf;
    logic [127:0] bdata;
    logic [2:0] beat;
    logic width_set;
    logic width_16;
    logic req_ready;
    logic rd_valid;
    logic [31:0] rd_data;
    logic burst_rvalid;
    logic [15:0] burst_rdata;
    logic cycle_start_n;
    logic [3:0] space_select_n;
    logic [3:0] cycle_status;
    logic read_write;
    logic [31:1] bus_addr;
    logic high_byte_enable_n;
    logic [1:0] byte_lane_enable_n;
    logic [15:0] data_out;
    logic data_oe;
    logic bus_oe;
    logic hold_acknowledge_n;
  } unit_t;

endpackage

// ===== hdl/cpu_bus_unit.sv
`timescale 1ns/100ps
`include "bus_unit_consts.svh"
// Summary of operation
// R1: memory and i/o cycles share timing; only the status code differs.
// R2: byte/half read: address, cycle start, select at address state; then start drops.
// R3: ready sampled after each short wait; the state repeats while ready is inactive.
// R4: single read captures bus data on the edge where ready is active.
// R5: word read re-outputs address in second word state; both word states wait on ready.
// R6: one idle state always follows a single read cycle.
// R7: byte/half write: address, data and cycle start at address state; hold data.
// R8: word write outputs address and upper halfword in the second word state.
// R9: bursts are memory only and move four words in either direction.
// R10: burst read waits per beat, captures data, new address each beat, eight beats.
// R11: one idle state always follows a burst read.
// R12: burst write drives first data in beat one, then next halfword each ready beat.
// R13: atomic exchange drives the locked code from its read cycle start.
// R14: locked code removed at the end of the atomic sequence's last write.
// R15: each locked read and write uses address, first and second word states.
// R16: hold request and ready both active at cycle end: idle with hold acknowledge.
// R17: hold request still active in idle with acknowledge: enter hold state.
// R18: hold floats the bus until the request drops, then idle as owner.
// R19: locked bus refuses hold requests except during its last bus cycle.
// R20: four-entry posted write buffer; the processor continues after posting.
// R21: a full buffer stalls stores; on-chip writes bypass the buffer.
// R22: ordered accesses wait until the write buffer has fully drained.
// R23: hold is granted regardless of pending buffered writes.
// R24: word access is two halfwords, lower first, halfword address bit toggling.
// R25: bus width caught once after reset and never changed.
// R26: reset leaves idle, strobes and acknowledge inactive, buffer empty.
module cpu_bus_unit
  import bus_unit_pkg::*;
#(
  parameter int WBUF_DEPTH = `WBUF_DEPTH
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_io,
  input wire logic req_burst,
  input wire logic req_lock,
  input wire logic [1:0] req_size,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_wdata,
  input wire logic [127:0] req_burst_data,
  output logic req_ready,
  output logic rd_valid,
  output logic [31:0] rd_data,
  output logic burst_rvalid,
  output logic [15:0] burst_rdata,
  input wire logic st_valid,
  input wire logic st_internal,
  input wire logic [1:0] st_size,
  input wire logic [31:0] st_addr,
  input wire logic [31:0] st_data,
  output logic st_stall,
  input wire logic ready_n,
  input wire logic hold_request_n,
  input wire logic [15:0] data_in,
  input wire logic bus_width_strap,
  output logic cycle_start_n,
  output logic [3:0] space_select_n,
  output logic [3:0] cycle_status,
  output logic read_write,
  output logic [31:1] bus_addr,
  output logic high_byte_enable_n,
  output logic [1:0] byte_lane_enable_n,
  output logic [15:0] data_out,
  output logic data_oe,
  output logic bus_oe,
  output logic hold_acknowledge_n,
  output logic bus_width_16
);

  ////////////////////////////////////////////////////////////////////////////

  localparam unit_t UNIT_RESET = '{
    state: ST_IDLE,
    cycle_start_n: 1'b1,
    space_select_n: 4'hf,
    cycle_status: `STATUS_IDLE,
    read_write: 1'b1,
    bus_addr: '1,
    high_byte_enable_n: 1'b1,
    byte_lane_enable_n: 2'h3,
    bus_oe: 1'b1,
    hold_acknowledge_n: 1'b1,
    default: '0
  };

  unit_t r;
  unit_t next_r;
  logic [`SYNC_WIDTH-1:0] pins_s;
  logic ready;
  logic hreq;
  logic strap_s;
  logic [15:0] din;
  logic done;
  logic buf_pop;
  logic buf_valid;
  logic buf_full;
  logic [`WBUF_WIDTH-1:0] buf_head;
  logic [2:0] nb;
  logic sync_live;

  ////////////////////////////////////////////////////////////////////////////
  // pins pass two flops; data rides with ready so they stay aligned

  sync2 #(
    .WIDTH(`SYNC_WIDTH)
  ) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .din({ready_n, hold_request_n, bus_width_strap, data_in}),
    .dout(pins_s)
  );

  // pins read as idle until the second flop holds a real sample, so no false hold after reset
  sync2 #(
    .WIDTH(1)
  ) u_live (
    .mclk(mclk),
    .nrst(nrst),
    .din(1'b1),
    .dout(sync_live)
  );

  assign ready = sync_live && !pins_s[18];
  assign hreq = sync_live && !pins_s[17];
  assign strap_s = pins_s[16];
  assign din = pins_s[15:0];

  // stores to on-chip memory never enter the buffer, yet still see st_stall while it is full
  post_write_fifo #(
    .WIDTH(`WBUF_WIDTH),
    .DEPTH(WBUF_DEPTH)
  ) u_wbuf (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(st_valid && !st_internal), // R20 R21
    .in_data({st_size, st_addr, st_data}),
    .full(buf_full),
    .out_valid(buf_valid),
    .out_data(buf_head),
    .out_ready(buf_pop)
  );

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [2:0] lane_decode(input logic [1:0] sz, input logic a0);
    if (sz == `SIZE_BYTE) begin
      return {1'b1, !a0, a0};
    end else if (sz == `SIZE_HALF) begin
      return 3'h4;
    end
    return 3'h0;
  endfunction

  function automatic unit_t launch(
    input unit_t s,
    input logic wr,
    input logic io,
    input logic bu,
    input logic lk,
    input logic [1:0] sz,
    input logic [31:0] a,
    input logic [31:0] d
  );
    logic [2:0] en;
    en = lane_decode(sz, a[0]);
    s.state = ST_ADDR;
    s.write = wr;
    s.io = io && !bu; // R9
    s.burst = bu;
    s.lock = lk;
    s.size = sz;
    s.addr = a;
    s.wdata = d;
    s.beat = 3'h0;
    s.cycle_start_n = 1'b0; // R2 R7
    s.bus_oe = 1'b1;
    s.read_write = !wr;
    s.bus_addr = a[31:1];
    s.high_byte_enable_n = en[2];
    s.byte_lane_enable_n = en[1:0];
    s.space_select_n = ~(4'h1 << a[`SPACE_MSB:`SPACE_LSB]);
    if (lk) begin
      s.cycle_status = `STATUS_LOCKED; // R13
    end else if (io && !bu) begin
      s.cycle_status = wr ? `STATUS_IO_WRITE : `STATUS_IO_READ; // R1
    end else begin
      s.cycle_status = wr ? `STATUS_MEM_WRITE : `STATUS_MEM_READ; // R1
    end
    // a byte rides both lanes so either enabled lane carries it
    s.data_out = (sz == `SIZE_BYTE) ? {d[7:0], d[7:0]} : d[15:0];
    s.data_oe = wr && !bu; // R7 R12
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_r = r;
    done = 1'b0;
    buf_pop = 1'b0;
    nb = r.beat + 3'h1;
    next_r.req_ready = 1'b0;
    next_r.rd_valid = 1'b0;
    next_r.burst_rvalid = 1'b0;
    if (!r.width_set && sync_live) begin
      next_r.width_set = 1'b1; // R25
      next_r.width_16 = strap_s; // R25
    end
    case (r.state)
      ST_IDLE: begin
        if (!r.hold_acknowledge_n) begin
          if (hreq) begin
            next_r.state = ST_HOLD; // R17
            next_r.bus_oe = 1'b0; // R18
          end else begin
            next_r.hold_acknowledge_n = 1'b1;
          end
        end else if (hreq && !r.lock) begin
          // buffered writes wait; the grant does not look at them
          next_r.hold_acknowledge_n = 1'b0; // R23
        end else if (r.lock) begin
          next_r = launch(next_r, 1'b1, 1'b0, 1'b0, 1'b1, `SIZE_WORD, r.addr, r.wdata); // R15
          next_r.lock_wr = 1'b1;
        end else if (req_valid && !buf_valid) begin
          next_r = launch(next_r, req_write && !req_lock, req_io, req_burst, req_lock,
                          req_lock ? `SIZE_WORD : req_size, req_addr, req_wdata); // R22
          next_r.bdata = req_burst_data;
          next_r.lock_wr = 1'b0;
          next_r.req_ready = 1'b1;
        end else if (buf_valid) begin
          next_r = launch(next_r, 1'b1, 1'b0, 1'b0, 1'b0, buf_head[65:64],
                          buf_head[63:32], buf_head[31:0]);
          buf_pop = 1'b1;
        end
      end
      ST_ADDR: begin
        next_r.cycle_start_n = 1'b1; // R2 R7
        if (r.burst) begin
          next_r.state = ST_BURST;
          if (r.write) begin
            next_r.data_out = r.bdata[15:0]; // R12
            next_r.data_oe = 1'b1; // R12
          end
        end else if (r.size == `SIZE_WORD) begin
          next_r.state = ST_WORD1; // R15
        end else begin
          next_r.state = ST_SHORT; // R2
        end
      end
      ST_SHORT: begin
        if (ready) begin // R3
          if (!r.write) begin
            next_r.rd_valid = 1'b1;
            if (r.size == `SIZE_BYTE) begin
              next_r.rd_data = {24'h0, r.addr[0] ? din[15:8] : din[7:0]}; // R4
            end else begin
              next_r.rd_data = {16'h0, din}; // R4
            end
          end
          done = 1'b1;
        end
      end
      ST_WORD1: begin
        if (ready) begin // R5
          if (!r.write) begin
            next_r.rbuf = {16'h0, din}; // R24
          end
          next_r.state = ST_WORD2;
          next_r.bus_addr[1] = 1'b1; // R5 R24
          if (r.write) begin
            next_r.data_out = r.wdata[31:16]; // R8
          end
        end
      end
      ST_WORD2: begin
        if (ready) begin // R5
          if (!r.write) begin
            next_r.rd_data = {din, r.rbuf[15:0]}; // R4
            next_r.rd_valid = 1'b1;
          end
          done = 1'b1;
        end
      end
      ST_BURST: begin
        if (ready) begin // R10
          if (!r.write) begin
            next_r.burst_rdata = din; // R10
            next_r.burst_rvalid = 1'b1;
          end
          if (r.beat == `BURST_LAST_BEAT) begin
            done = 1'b1; // R11
          end else begin
            next_r.beat = nb;
            next_r.bus_addr[3:1] = nb; // R10
            if (r.write) begin
              next_r.data_out = r.bdata[{nb, 4'h0} +: 16]; // R12
            end
          end
        end
      end
      ST_HOLD: begin
        if (!hreq) begin
          next_r.state = ST_IDLE; // R18
          next_r.hold_acknowledge_n = 1'b1;
          next_r.bus_oe = 1'b1;
        end
      end
      default: begin
        next_r = UNIT_RESET;
      end
    endcase

    // common close of a cycle: reads and bursts always leave through idle
    if (done) begin
      next_r.state = ST_IDLE; // R6 R11
      next_r.space_select_n = 4'hf;
      next_r.data_oe = 1'b0;
      next_r.read_write = 1'b1;
      next_r.cycle_status = `STATUS_IDLE;
      if (r.lock && !r.lock_wr) begin
        next_r.cycle_status = `STATUS_LOCKED; // R13
      end else begin
        next_r.lock = 1'b0; // R14
      end
      if (hreq && (!r.lock || r.lock_wr)) begin
        next_r.hold_acknowledge_n = 1'b0; // R16 R19
      end else if (r.write && !r.burst && !r.lock && buf_valid) begin
        // posted writes may follow back to back without an idle state
        next_r = launch(next_r, 1'b1, 1'b0, 1'b0, 1'b0, buf_head[65:64],
                        buf_head[63:32], buf_head[31:0]);
        buf_pop = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r <= UNIT_RESET; // R26
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign req_ready = r.req_ready;
  assign rd_valid = r.rd_valid;
  assign rd_data = r.rd_data;
  assign burst_rvalid = r.burst_rvalid;
  assign burst_rdata = r.burst_rdata;
  assign st_stall = buf_full; // R21
  assign cycle_start_n = r.cycle_start_n;
  assign space_select_n = r.space_select_n;
  assign cycle_status = r.cycle_status;
  assign read_write = r.read_write;
  assign bus_addr = r.bus_addr;
  assign high_byte_enable_n = r.high_byte_enable_n;
  assign byte_lane_enable_n = r.byte_lane_enable_n;
  assign data_out = r.data_out;
  assign data_oe = r.data_oe;
  assign bus_oe = r.bus_oe;
  assign hold_acknowledge_n = r.hold_acknowledge_n;
  assign bus_width_16 = r.width_16;

endmodule

// ===== hdl/post_write_fifo.sv
`timescale 1ns/100ps
`include "bus_unit_consts.svh"
module post_write_fifo #(
  parameter int WIDTH = `WBUF_WIDTH,
  parameter int DEPTH = `WBUF_DEPTH
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic full,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
  } fifo_t;
  fifo_t r;
  fifo_t next_r;
  logic push;
  logic pop;
  always_comb begin
    next_r = r;
    push = in_valid && !r.full;
    pop = out_ready && (r.cnt != '0);
    if (push) begin
      next_r.mem[r.wp] = in_data;
      next_r.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      next_r.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
    end
    if (push && !pop) begin
      next_r.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      next_r.cnt = r.cnt - 1'b1;
    end
    next_r.full = (next_r.cnt == (AW + 1)'(DEPTH));
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign full = r.full;
  assign out_valid = (r.cnt != '0);
  assign out_data = r.mem[r.rp];
endmodule

// ===== hdl/sync2.sv
`timescale 1ns/100ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_t;
  sync_t r;
  sync_t next_r;
  always_comb begin
    next_r.s1 = din;
    next_r.s2 = r.s1;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign dout = r.s2;
endmodule

// ===== testbench/cpu_bus_unit_asserts.sv
`timescale 1ns/100ps
`include "bus_unit_consts.svh"
module bus_check (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic req_ready,
  input wire logic rd_valid,
  input wire logic cycle_start_n,
  input wire logic [3:0] space_select_n,
  input wire logic [3:0] cycle_status,
  input wire logic read_write,
  input wire logic [31:1] bus_addr,
  input wire logic data_oe,
  input wire logic bus_oe,
  input wire logic hold_acknowledge_n,
  input wire logic bus_width_16
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  start_pulse_a: assert property ($fell(cycle_start_n) |=> cycle_start_n)
    else $error("cycle start held past the address state");
  taken_start_a: assert property (req_ready |-> !cycle_start_n && space_select_n != 4'hf)
    else $error("request taken outside an address state");
  addr_hold_a: assert property (!cycle_start_n |=> $stable(bus_addr[31:4]) && $stable(space_select_n))
    else $error("address moved after cycle start");
  read_idle_a: assert property (rd_valid |-> cycle_start_n && space_select_n == 4'hf)
    else $error("no idle state after read");
  write_data_a: assert property (data_oe |-> !read_write && bus_oe)
    else $error("data driven outside a write");
  hold_float_a: assert property (!bus_oe |-> !hold_acknowledge_n && !data_oe && cycle_start_n)
    else $error("bus floated without hold");
  ack_idle_a: assert property ($fell(hold_acknowledge_n) |-> cycle_start_n && space_select_n == 4'hf)
    else $error("hold acknowledged outside idle");
  lock_nohold_a: assert property (cycle_status == `STATUS_LOCKED |-> hold_acknowledge_n)
    else $error("hold granted on locked bus");
  regain_bus_a: assert property ($rose(bus_oe) |-> hold_acknowledge_n && cycle_start_n)
    else $error("bus regained without idle");
  width_fixed_a: assert property ($changed(bus_width_16) |=> $stable(bus_width_16) [*8])
    else $error("bus width changed again");
  cover property ($fell(hold_acknowledge_n));
  cover property (!cycle_start_n && cycle_status == `STATUS_LOCKED);
  cover property (rd_valid);
endmodule
bind cpu_bus_unit bus_check chk (.mclk, .nrst, .req_ready, .rd_valid, .cycle_start_n,
  .space_select_n, .cycle_status, .read_write, .bus_addr, .data_oe, .bus_oe,
  .hold_acknowledge_n, .bus_width_16);

// ===== testbench/ext_memory.sv
`timescale 1ns/100ps
module ext_memory (
  input wire logic mclk,
  input wire logic cycle_start_n,
  input wire logic [3:0] cycle_status,
  input wire logic read_write,
  input wire logic [31:1] bus_addr,
  input wire logic [15:0] data_out,
  input wire logic [7:0] waits,
  output logic ready_n,
  output logic [15:0] data_in
);
  logic [15:0] mem [32];
  logic [7:0] cnt = 8'hff;
  logic [31:1] last;
  logic hit;
  initial for (int i = 0; i < 32; i++) mem[i] = {11'h5a6, i[4:0]};
  // one ready pulse per address, so a stale pulse never paces the next beat
  assign hit = cycle_start_n && cycle_status != 4'hf && cnt == waits;
  assign ready_n = !hit;
  // outside the answer the lines show the inverse, never a held value
  assign data_in = (hit && read_write) ? mem[bus_addr[5:1]] : ~mem[bus_addr[5:1]];
  always @(posedge mclk) begin
    last <= bus_addr;
    if (!cycle_start_n || bus_addr != last) cnt <= 8'h00;
    else if (cnt != 8'hff) cnt <= cnt + 8'h01;
    if (hit && !read_write) mem[bus_addr[5:1]] <= data_out;
  end
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/100ps
`include "bus_unit_consts.svh"
module tb_top;
  logic mclk = 1'h0;
  logic nrst = 1'h0;
  logic req_valid = 1'h0, req_write = 1'h0, req_io = 1'h0, req_burst = 1'h0, req_lock = 1'h0;
  logic [1:0] req_size = 2'h0, st_size = 2'h1;
  logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, st_addr = 32'h0, st_data = 32'h0;
  logic [127:0] req_burst_data = 128'h0;
  logic st_valid = 1'h0, st_internal = 1'h0, hold_request_n = 1'h1, bus_width_strap = 1'h1;
  logic [7:0] waits = 8'h02;
  logic req_ready, rd_valid, burst_rvalid, st_stall, ready_n, cycle_start_n, read_write;
  logic high_byte_enable_n, data_oe, bus_oe, hold_acknowledge_n, bus_width_16;
  logic [31:0] rd_data;
  logic [15:0] burst_rdata, data_in, data_out;
  logic [3:0] space_select_n, cycle_status;
  logic [31:1] bus_addr;
  logic [1:0] byte_lane_enable_n;
  int failures = 0;
  int checks_done = 0;
  cpu_bus_unit uut (.mclk, .nrst, .req_valid, .req_write, .req_io, .req_burst, .req_lock,
    .req_size, .req_addr, .req_wdata, .req_burst_data, .req_ready, .rd_valid, .rd_data,
    .burst_rvalid, .burst_rdata, .st_valid, .st_internal, .st_size, .st_addr, .st_data,
    .st_stall, .ready_n, .hold_request_n, .data_in, .bus_width_strap, .cycle_start_n,
    .space_select_n, .cycle_status, .read_write, .bus_addr, .high_byte_enable_n,
    .byte_lane_enable_n, .data_out, .data_oe, .bus_oe, .hold_acknowledge_n, .bus_width_16);
  ext_memory mem_i (.mclk, .cycle_start_n, .cycle_status, .read_write, .bus_addr, .data_out,
    .waits, .ready_n, .data_in);
  always #20 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] init_val(input int i);
    return {11'h5a6, i[4:0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // kind packs write, io, burst, lock, size
  task automatic request(input logic [5:0] kind, input logic [31:0] a, input logic [31:0] d,
      output logic [3:0] st);
    int n;
    @(posedge mclk);
    {req_write, req_io, req_burst, req_lock, req_size} <= kind;
    req_addr <= a;
    req_wdata <= d;
    req_valid <= 1'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (req_ready !== 1'h1 && n < 300);
    st = cycle_status;
    req_valid <= 1'h0;
    check(32'(n < 300), 32'h1);
  endtask
  task automatic wait_sig(input int sel);
    int n;
    for (n = 0; n < 300; n++) begin
      @(posedge mclk);
      if ((sel == 0 && rd_valid === 1'h1) || (sel == 1 && bus_oe === 1'h0) ||
          (sel == 2 && bus_oe === 1'h1 && hold_acknowledge_n === 1'h1) ||
          (sel == 3 && burst_rvalid === 1'h1)) break;
    end
    check(32'(n < 300), 32'h1);
  endtask
  task automatic mem_wait(input int i, input logic [15:0] exp);
    for (int n = 0; n < 300 && mem_i.mem[i] !== exp; n++) @(posedge mclk);
    check(32'(mem_i.mem[i]), 32'(exp));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_single;
    logic [3:0] st;
    request(6'h01, 32'h4, 32'h0, st);
    check(32'(st), 32'(`STATUS_MEM_READ));
    check(32'({high_byte_enable_n, byte_lane_enable_n}), 32'h4);
    wait_sig(0);
    check(32'(rd_data[15:0]), 32'(init_val(2)));
    request(6'h00, 32'h7, 32'h0, st);
    check(32'({high_byte_enable_n, byte_lane_enable_n}), 32'h5);
    wait_sig(0);
    check(rd_data, 32'(init_val(3) >> 8));
    waits <= 8'h00;
    request(6'h12, 32'h8, 32'h0, st);
    check(32'(st), 32'(`STATUS_IO_READ));
    check(32'({high_byte_enable_n, byte_lane_enable_n}), 32'h0);
    wait_sig(0);
    check(rd_data, {init_val(5), init_val(4)});
    request(6'h22, 32'h10, 32'h1234abcd, st);
    check(32'(st), 32'(`STATUS_MEM_WRITE));
    mem_wait(8, 16'habcd);
    mem_wait(9, 16'h1234);
    request(6'h31, 32'h14, 32'h5555beef, st);
    check(32'(st), 32'(`STATUS_IO_WRITE));
    mem_wait(10, 16'hbeef);
  endtask
  task automatic t_burst;
    logic [3:0] st;
    logic [127:0] bd;
    request(6'h0a, 32'h20, 32'h0, st);
    check(32'(st), 32'(`STATUS_MEM_READ));
    for (int k = 0; k < 8; k++) begin
      wait_sig(3);
      check(32'(burst_rdata), 32'(init_val(16 + k)));
    end
    for (int k = 0; k < 8; k++) bd[16 * k +: 16] = 16'hc0d0 + 16'(k);
    req_burst_data <= bd;
    request(6'h2a, 32'h0, 32'h0, st);
    for (int k = 0; k < 8; k++) mem_wait(k, 16'hc0d0 + 16'(k));
  endtask
  task automatic t_lock;
    logic [3:0] st;
    request(6'h06, 32'h30, 32'h77778888, st);
    check(32'(st), 32'(`STATUS_LOCKED));
    hold_request_n <= 1'h0;
    wait_sig(0);
    check(rd_data, {init_val(25), init_val(24)});
    check(32'(hold_acknowledge_n), 32'h1);
    wait_sig(1);
    check(32'({mem_i.mem[24], mem_i.mem[25]}), 32'h88887777);
    hold_request_n <= 1'h1;
    wait_sig(2);
    mem_wait(24, 16'h8888);
    mem_wait(25, 16'h7777);
  endtask
  task automatic t_store;
    logic [3:0] st;
    int i = 0;
    int stalls = 0;
    @(posedge mclk);
    waits <= 8'h06;
    {st_internal, st_valid} <= 2'h3;
    st_addr <= 32'h3e;
    st_data <= 32'h0000dead;
    @(posedge mclk);
    st_internal <= 1'h0;
    while (i < 6 && stalls < 300) begin
      st_addr <= 32'h32 + 32'(2 * i);
      st_data <= 32'h9000 + 32'(i);
      @(posedge mclk);
      if (st_stall === 1'h1) stalls++;
      else i++;
    end
    st_valid <= 1'h0;
    check(32'(stalls > 0 && stalls < 300), 32'h1);
    request(6'h01, 32'h3c, 32'h0, st);
    check(32'(mem_i.mem[30]), 32'h9005);
    wait_sig(0);
    for (int k = 0; k < 6; k++) check(32'(mem_i.mem[25 + k]), 32'h9000 + 32'(k));
    check(32'(mem_i.mem[31]), 32'(init_val(31)));
  endtask
  task automatic t_hold;
    @(posedge mclk);
    st_valid <= 1'h1;
    st_addr <= 32'h18;
    st_data <= 32'h00001111;
    @(posedge mclk);
    st_addr <= 32'h1a;
    st_data <= 32'h00002222;
    hold_request_n <= 1'h0;
    @(posedge mclk);
    st_valid <= 1'h0;
    wait_sig(1);
    check(32'({hold_acknowledge_n, mem_i.mem[13] === 16'h2222}), 32'h0);
    repeat (5) @(posedge mclk);
    check(32'(bus_oe), 32'h0);
    hold_request_n <= 1'h1;
    wait_sig(2);
    mem_wait(13, 16'h2222);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge mclk);
    check(32'({cycle_start_n, hold_acknowledge_n, st_stall, space_select_n, cycle_status}),
      32'h6ff);
    nrst <= 1'h1;
    t_single;
    check(32'(bus_width_16), 32'h1);
    t_burst;
    t_lock;
    t_store;
    t_hold;
    complete_run;
  end
  // all scenarios take a few hundred cycles; this leaves wide margin
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    complete_run;
  end
endmodule
